// *** design/ptpr_link_if.sv ***
// Interface: byte access between the serial slave and the register bank
`timescale 1ns/100ps
interface ptpr_link_if;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic sda_oe;
	modport slave (output wr, addr, wdata, sda_oe, input rdata);
	modport bank (input wr, addr, wdata, sda_oe, output rdata);
endinterface : ptpr_link_if

// *** design/ptpr_pkg.sv ***
// Package: constants shared by the port timing and pushbutton register slice
package ptpr_pkg;
	localparam int PORTS = 4;
	localparam int MODE_W = 2;
	localparam int CLASS_W = 3;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Register offsets
	localparam logic [7:0] REG_TIMER = 8'h16;
	localparam logic [7:0] REG_MISC = 8'h17;
	localparam logic [7:0] REG_BUTTON = 8'h19;
	localparam logic [7:0] REG_GLOBAL = 8'h1a;
	localparam logic [7:0] REG_IDENT = 8'h1b;
	// Timer scaling field positions
	localparam int RESTART_LSB = 6;
	localparam int START_LSB = 4;
	localparam int FAULT_LSB = 2;
	localparam int DISC_LSB = 0;
	// Misc configuration bit positions
	localparam int MISC_INT_EN = 7;
	localparam int MISC_RESTART_EN = 6;
	localparam int MISC_CLASS_BLOCK = 3;
	localparam int MISC_CAP = 2;
	localparam int MISC_ISO = 1;
	localparam int MISC_HP_EARLY = 0;
	// Pushbutton bit positions
	localparam int BTN_OFF_LSB = 4;
	localparam int GLB_CLEAR = 7;
	localparam int GLB_CHIP = 4;
	// Reset values
	localparam logic [7:0] MISC_RESET = 8'hc0;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	// Port operating modes
	localparam logic [1:0] MODE_SHUT = 2'h0;
	localparam logic [1:0] MODE_MAN = 2'h1;
	localparam logic [1:0] MODE_SEMI = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;
	localparam logic [2:0] CLASS_HP_MIN = 3'h4;
	localparam logic [2:0] CLASS_HP_MAX = 3'h6;
	// Timing: 100 MHz clock, 100 us time base tick
	localparam int CLK_NS = 10;
	localparam int TICK_US = 100;
	localparam int TICK_CYC_DEF = TICK_US * 1000 / CLK_NS;
	localparam int T_START_US = 60000;
	localparam int T_FAULT_US = 60000;
	localparam int T_DISC_US = 350000;
	localparam int T_CGAP_US = 21300;
	localparam int START_TK = T_START_US / TICK_US;
	localparam int FAULT_TK = T_FAULT_US / TICK_US;
	localparam int DISC_TK = T_DISC_US / TICK_US;
	localparam int CGAP_TK = T_CGAP_US / TICK_US;
	localparam logic [1:0] CLASS_REPEAT = 2'h3;
	// Counter widths
	localparam int OC_W = 12;
	localparam int RS_W = 18;
	localparam int DC_W = 13;
	localparam int GAP_W = 8;
	localparam int DIV_W = 16;
	// Identity and link address, values arbitrary
	localparam logic [4:0] IDENT_CODE_DEF = 5'h0a;
	localparam logic [2:0] SILICON_VER_DEF = 3'h1;
	localparam logic [6:0] DEV_ADDR_DEF = 7'h20;
endpackage : ptpr_pkg

// *** design/ptpr_regs.sv ***
// Register slice top: timer scaling, misc config, pushbuttons, identity, port power
`timescale 1ns/100ps
module ptpr_regs
	import ptpr_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF,
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter logic [4:0] IDENT_CODE = IDENT_CODE_DEF,
	parameter logic [2:0] SILICON_VER = SILICON_VER_DEF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic int_oe,
	input wire logic [MODE_W*PORTS-1:0] port_mode,
	input wire logic [CLASS_W*PORTS-1:0] port_class,
	input wire logic [PORTS-1:0] class_fault,
	input wire logic block_power_on_class_fault,
	input wire logic [PORTS-1:0] discovery_busy,
	input wire logic [PORTS-1:0] auto_power_req,
	input wire logic [PORTS-1:0] in_current_limit,
	input wire logic [PORTS-1:0] power_good,
	input wire logic [PORTS-1:0] mps_absent,
	input wire logic [PORTS-1:0] class_start,
	input wire logic [PORTS-1:0] two_event_class_enable,
	input wire logic global_high_power_enable,
	input wire logic [2:0] per_class_high_power_enable,
	input wire logic event_pending,
	output logic [PORTS-1:0] port_power_en,
	output logic [PORTS-1:0] discovery_abort,
	output logic [PORTS-1:0] port_soft_reset,
	output logic clear_events,
	output logic chip_soft_reset,
	output logic [PORTS-1:0] class_trigger,
	output logic [PORTS-1:0] hold_mark_voltage,
	output logic [PORTS-1:0] high_current_en,
	output logic [PORTS-1:0] class_limit_en,
	output logic [PORTS-1:0] discovery_sense_pin_hiz
);
	typedef struct packed {
		logic [7:0] tcfg;
		logic int_en;
		logic autorestart_enable;
		logic class_current_cap;
		logic iso;
		logic high_power_after_startup;
		logic [DIV_W-1:0] div;
		logic tick;
		logic [PORTS-1:0] power;
		logic [PORTS-1:0] started;
		logic [PORTS-1:0] hold9;
		logic [PORTS-1:0] ctrig;
		logic [PORTS-1:0] abort;
		logic [PORTS-1:0] prst;
		logic [PORTS-1:0] hicur;
		logic [PORTS-1:0] cap;
		logic [PORTS-1:0] hiz;
		logic [PORTS-1:0][OC_W-1:0] oc;
		logic [PORTS-1:0][RS_W-1:0] rs;
		logic [PORTS-1:0][DC_W-1:0] dc;
		logic [PORTS-1:0][1:0] cleft;
		logic [PORTS-1:0][GAP_W-1:0] gap;
		logic clr_ev;
		logic chip_rst;
		logic int_oe;
		logic sda_out;
	} ptpr_st_t;
	ptpr_st_t q;
	ptpr_st_t n;
	ptpr_link_if lk ();
	logic wr_timer;
	logic wr_misc;
	logic wr_btn;
	logic wr_glb;
	logic [1:0] restart_time_sel;
	logic [1:0] disconnect_time_sel;
	logic [OC_W-1:0] lim_start;
	logic [OC_W-1:0] lim_fault;
	logic [DC_W-1:0] lim_disc;
	logic [RS_W-1:0] lim_restart;
	logic [7:0] rd;
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	// misc resets to c0
	// Reset image of the whole state
	function automatic ptpr_st_t reset_state();
		ptpr_st_t s;
		s = '0;
		s.tcfg = TIMER_RESET;
		s.int_en = MISC_RESET[MISC_INT_EN];
		s.autorestart_enable = MISC_RESET[MISC_RESTART_EN];
		s.class_current_cap = MISC_RESET[MISC_CAP];
		s.iso = MISC_RESET[MISC_ISO];
		s.high_power_after_startup = MISC_RESET[MISC_HP_EARLY];
		return s;
	endfunction : reset_state
	// Scale 1, 1/2, 2, 4
	function automatic logic [OC_W-1:0] scale_up(input logic [1:0] c, input int nom);
		logic [OC_W-1:0] v;
		v = OC_W'(nom);
		unique case (c)
			2'h0: return v;
			2'h1: return v >> 1;
			2'h2: return v << 1;
			2'h3: return v << 2;
		endcase
	endfunction : scale_up
	// per-class enables, class 4 first
	// High current allowed for class 4 to 6 with both enables
	function automatic logic hp_allowed(input logic [2:0] cls, input logic glob,
		input logic [2:0] per);
		logic [2:0] idx;
		idx = cls - CLASS_HP_MIN;
		return glob && cls >= CLASS_HP_MIN && cls <= CLASS_HP_MAX && per[idx[1:0]];
	endfunction : hp_allowed
	////////////////////////////////////////////////////////////////////////////////
	// Serial management link
	ptpr_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_link (
		.clk(clk),
		.arst_n(arst_n),
		.scl(scl),
		.sda_in(sda_in),
		.lk(lk.slave)
	);
	// Write decodes
	assign wr_timer = lk.wr && lk.addr == REG_TIMER;
	assign wr_misc = lk.wr && lk.addr == REG_MISC;
	assign wr_btn = lk.wr && lk.addr == REG_BUTTON;
	assign wr_glb = lk.wr && lk.addr == REG_GLOBAL;
	assign restart_time_sel = q.tcfg[RESTART_LSB +: 2];
	assign disconnect_time_sel = q.tcfg[DISC_LSB +: 2];
	assign lim_start = scale_up(q.tcfg[START_LSB +: 2], START_TK);
	assign lim_fault = scale_up(q.tcfg[FAULT_LSB +: 2], FAULT_TK);
	always_comb begin
		lim_disc = DC_W'(DISC_TK);
		unique case (disconnect_time_sel)
			2'h0: lim_disc = DC_W'(DISC_TK);
			2'h1: lim_disc = DC_W'(DISC_TK) >> 2;
			2'h2: lim_disc = DC_W'(DISC_TK) >> 1;
			2'h3: lim_disc = DC_W'(DISC_TK) << 1;
		endcase
	end
	// restart off time from fault time
	always_comb begin
		lim_restart = '0;
		unique case (restart_time_sel)
			2'h0: lim_restart = RS_W'(lim_fault) << 4;
			2'h1: lim_restart = RS_W'(lim_fault) << 5;
			2'h2: lim_restart = RS_W'(lim_fault) << 6;
			2'h3: lim_restart = '0;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [1:0] md;
		logic [2:0] cls;
		logic on_req;
		logic off;
		logic fault;
		logic disc;
		logic two_ev;
		md = '0;
		cls = '0;
		on_req = 1'b0;
		off = 1'b0;
		fault = 1'b0;
		disc = 1'b0;
		two_ev = 1'b0;
		n = q;
		n.clr_ev = 1'b0;
		n.chip_rst = 1'b0;
		n.prst = '0;
		n.abort = '0;
		n.ctrig = '0;
		// Time base tick
		n.tick = 1'b0;
		n.div = q.div + DIV_W'(1);
		if (q.div == DIV_W'(TICK_CYC - 1)) begin
			n.div = '0;
			n.tick = 1'b1;
		end
		if (wr_timer) n.tcfg = lk.wdata;
		// reserved and read-only bits not stored
		if (wr_misc) begin
			n.int_en = lk.wdata[MISC_INT_EN];
			n.autorestart_enable = lk.wdata[MISC_RESTART_EN];
			n.class_current_cap = lk.wdata[MISC_CAP];
			n.iso = lk.wdata[MISC_ISO];
			n.high_power_after_startup = lk.wdata[MISC_HP_EARLY];
		end
		if (wr_glb && lk.wdata[GLB_CLEAR]) n.clr_ev = 1'b1;
		n.int_oe = q.int_en && event_pending;
		n.hiz = {PORTS{q.iso}};
		n.cap = {PORTS{q.class_current_cap}};
		for (int p = 0; p < PORTS; p++) begin
			md = port_mode[p*MODE_W +: MODE_W];
			cls = port_class[p*CLASS_W +: CLASS_W];
			if (q.tick && q.rs[p] != '0) n.rs[p] = q.rs[p] - RS_W'(1);
			if (q.power[p] && in_current_limit[p]) begin
				if (q.tick) n.oc[p] = q.oc[p] + OC_W'(1);
			end else begin
				n.oc[p] = '0;
			end
			if (q.power[p] && power_good[p]) n.started[p] = 1'b1;
			fault = q.power[p] && q.oc[p] >= (q.started[p] ? lim_fault : lim_start);
			if (q.power[p] && q.started[p] && mps_absent[p]) begin
				if (q.tick) n.dc[p] = q.dc[p] + DC_W'(1);
			end else begin
				n.dc[p] = '0;
			end
			disc = q.power[p] && q.dc[p] >= lim_disc;
			on_req = wr_btn && lk.wdata[p] && md != MODE_SHUT && md != MODE_AUTO && !q.power[p];
			if (on_req && discovery_busy[p]) n.abort[p] = 1'b1;
			if (md == MODE_AUTO && auto_power_req[p])
				on_req = !(block_power_on_class_fault && class_fault[p]);
			off = wr_btn && lk.wdata[BTN_OFF_LSB + p] && q.power[p] && md != MODE_SHUT;
			if (wr_glb && lk.wdata[p]) n.prst[p] = 1'b1;
			off = off || fault || disc || md == MODE_SHUT || (wr_glb && lk.wdata[p]);
			if (off) begin
				n.power[p] = 1'b0;
				n.started[p] = 1'b0;
				n.oc[p] = '0;
				n.dc[p] = '0;
				if (fault && q.autorestart_enable) n.rs[p] = lim_restart;
			end else if (on_req && q.rs[p] == '0) begin
				n.power[p] = 1'b1;
			end
			n.hicur[p] = hp_allowed(cls, global_high_power_enable, per_class_high_power_enable);
			n.hicur[p] = n.hicur[p] && (q.started[p] ||
				(q.high_power_after_startup && global_high_power_enable));
			// 2-event only in auto or semi
			two_ev = two_event_class_enable[p] && (md == MODE_AUTO || md == MODE_SEMI);
			if (class_start[p]) begin
				n.ctrig[p] = 1'b1;
				n.cleft[p] = two_ev ? CLASS_REPEAT - 2'h1 : 2'h0;
				n.gap[p] = '0;
				n.hold9[p] = two_ev;
			end else if (q.cleft[p] != 2'h0 && q.tick) begin
				n.gap[p] = q.gap[p] + GAP_W'(1);
				if (q.gap[p] == GAP_W'(CGAP_TK - 1)) begin
					n.gap[p] = '0;
					n.ctrig[p] = 1'b1;
					n.cleft[p] = q.cleft[p] - 2'h1;
					n.hold9[p] = q.cleft[p] != 2'h1;
				end
			end
		end
		if (wr_glb && lk.wdata[GLB_CHIP]) begin
			n = reset_state();
			n.chip_rst = 1'b1;
			// Buttons written together with the reset still pulse
			n.clr_ev = lk.wdata[GLB_CLEAR];
			n.prst = lk.wdata[PORTS-1:0];
		end
	end
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) q <= reset_state();
		else q <= n;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Read data
	always_comb begin
		rd = '0;
		if (lk.addr == REG_TIMER) begin
			rd = q.tcfg;
		end else if (lk.addr == REG_MISC) begin
			rd[MISC_INT_EN] = q.int_en;
			rd[MISC_RESTART_EN] = q.autorestart_enable;
			rd[MISC_CLASS_BLOCK] = block_power_on_class_fault;
			rd[MISC_CAP] = q.class_current_cap;
			rd[MISC_ISO] = q.iso;
			rd[MISC_HP_EARLY] = q.high_power_after_startup;
		end else if (lk.addr == REG_IDENT) begin
			rd = {IDENT_CODE, SILICON_VER};
		end
	end
	assign lk.rdata = rd;
	// Outputs from state flops
	assign sda_out = q.sda_out;
	assign sda_oe = lk.sda_oe;
	assign int_oe = q.int_oe;
	assign port_power_en = q.power;
	assign discovery_abort = q.abort;
	assign port_soft_reset = q.prst;
	assign clear_events = q.clr_ev;
	assign chip_soft_reset = q.chip_rst;
	assign class_trigger = q.ctrig;
	assign hold_mark_voltage = q.hold9;
	assign high_current_en = q.hicur;
	assign class_limit_en = q.cap;
	assign discovery_sense_pin_hiz = q.hiz;
	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	timer_write_a: assert property (wr_timer && !wr_glb |=> q.tcfg == $past(lk.wdata))
		else $error("timer register write lost");
	misc_reset_a: assert property (chip_soft_reset |-> q.int_en && q.autorestart_enable
		&& !q.class_current_cap && !q.iso && !q.high_power_after_startup)
		else $error("misc register not at reset value");
	int_gate_a: assert property (!q.int_en |=> !int_oe)
		else $error("interrupt driven while disabled");
	iso_pins_a: assert property (q.iso |=> discovery_sense_pin_hiz == {PORTS{1'b1}})
		else $error("sense pins not isolated");
	button_shut_a: assert property (wr_btn && lk.wdata[0] && port_mode[1:0] == MODE_SHUT
		|=> !port_power_en[0])
		else $error("power-up accepted in shutdown");
	button_off_a: assert property (wr_btn && lk.wdata[BTN_OFF_LSB] && port_power_en[0]
		&& !wr_glb |=> !port_power_en[0])
		else $error("power-down ignored");
	restart_hold_a: assert property (q.rs[0] != '0 && !port_power_en[0]
		|=> !port_power_en[0])
		else $error("power-on during restart time");
	port_reset_a: assert property (wr_glb && lk.wdata[0] |=> port_soft_reset[0]
		&& !port_power_en[0] ##1 !port_soft_reset[0])
		else $error("port reset pulse wrong");
	clear_pulse_a: assert property (wr_glb && lk.wdata[GLB_CLEAR] |=> clear_events
		##1 !clear_events)
		else $error("clear events pulse wrong");
	hp_class_a: assert property (high_current_en[0] |-> $past(global_high_power_enable))
		else $error("high current without global enable");
	power_up_c: cover property (wr_btn && lk.wdata[0] ##1 port_power_en[0]);
	two_event_c: cover property (class_trigger[0] && hold_mark_voltage[0]);
	restart_c: cover property ($fell(port_power_en[0]) && q.rs[0] != '0);
	chip_reset_c: cover property (chip_soft_reset);
endmodule : ptpr_regs

// *** design/ptpr_serial_slave.sv ***
// Serial management slave: start/stop, address, pointer, byte writes and reads
`timescale 1ns/100ps
module ptpr_serial_slave
	import ptpr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda_in,
	ptpr_link_if.slave lk
);
	typedef enum logic [2:0] {SL_IDLE, SL_DEV, SL_PTR, SL_WR, SL_RD} ptpr_sl_st_t;
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_v;
		logic sda_v;
		ptpr_sl_st_t st;
		logic [7:0] sr;
		logic [3:0] cnt;
		logic ack;
		logic mack;
		logic [7:0] ptr;
		logic oe;
		logic wr;
	} ptpr_sl_t;
	ptpr_sl_t q;
	ptpr_sl_t n;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	////////////////////////////////////////////////////////////////////////////////
	// Pin filter, framing and byte engine
	always_comb begin
		n = q;
		n.wr = 1'b0;
		n.scl_s = {q.scl_s[1:0], scl};
		n.sda_s = {q.sda_s[1:0], sda_in};
		if (q.scl_s[1] == q.scl_s[2]) n.scl_v = q.scl_s[2];
		if (q.sda_s[1] == q.sda_s[2]) n.sda_v = q.sda_s[2];
		rise = n.scl_v & ~q.scl_v;
		fall = ~n.scl_v & q.scl_v;
		start = q.scl_v & n.scl_v & q.sda_v & ~n.sda_v;
		stop = q.scl_v & n.scl_v & ~q.sda_v & n.sda_v;
		// Pointer moves on after a written byte
		if (q.wr) n.ptr = q.ptr + 8'h01;
		if (start) begin
			n.st = SL_DEV;
			n.cnt = '0;
			n.ack = 1'b0;
			n.oe = 1'b0;
		end else if (stop) begin
			n.st = SL_IDLE;
			n.oe = 1'b0;
		end else if (q.st != SL_IDLE && rise) begin
			if (q.ack) n.mack = ~n.sda_v;
			else n.cnt = q.cnt + 4'h1;
			if (!q.ack && q.st != SL_RD) n.sr = {q.sr[6:0], n.sda_v};
		end else if (q.st != SL_IDLE && fall) begin
			if (q.ack) begin
				n.ack = 1'b0;
				n.cnt = '0;
				n.oe = 1'b0;
				if (q.st == SL_RD && q.mack) begin
					n.sr = lk.rdata;
					n.oe = ~lk.rdata[7];
					n.ptr = q.ptr + 8'h01;
				end else if (q.st == SL_RD) begin
					n.st = SL_IDLE;
				end
			end else if (q.cnt == BYTE_BITS) begin
				n.ack = 1'b1;
				n.oe = (q.st != SL_RD);
				unique case (q.st)
					SL_DEV: begin
						n.mack = 1'b1;
						n.st = q.sr[0] ? SL_RD : SL_PTR;
						if (q.sr[7:1] != DEV_ADDR) begin
							n.st = SL_IDLE;
							n.ack = 1'b0;
							n.oe = 1'b0;
						end
					end
					SL_PTR: begin
						n.ptr = q.sr;
						n.st = SL_WR;
					end
					SL_WR: n.wr = 1'b1;
					SL_RD, SL_IDLE: n.mack = 1'b0;
				endcase
			end else if (q.st == SL_RD) begin
				n.oe = ~q.sr[6];
				n.sr = {q.sr[6:0], 1'b0};
			end
		end
	end
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) q <= '0;
		else q <= n;
	end
	assign lk.wr = q.wr;
	assign lk.addr = q.ptr;
	assign lk.wdata = q.sr;
	assign lk.sda_oe = q.oe;
endmodule : ptpr_serial_slave

// *** verif/ptpr_host_model.sv ***
// Host model: serial management master on the link pins
`timescale 1ns/100ps
module ptpr_host_model
	import ptpr_pkg::*;
(
	output logic scl,
	output logic sda_pull,
	input wire logic sda_line
);
	localparam realtime Q = 31.25;
	logic nak, r;
	// Idle: clock stands high, data left to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// One link clock period: data set while low, line sampled mid high
	task automatic bit_io(input logic b);
		sda_pull = ~b;
		#Q scl = 1'b1;
		#Q r = sda_line;
		#Q scl = 1'b0;
		#Q;
	endtask : bit_io
	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask : start
	// Stop: data rises while the clock is high, clock then stands
	task automatic stop();
		sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#(2*Q);
	endtask : stop
	// Byte out MSB first, slave acknowledge kept in nak
	task automatic put_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) bit_io(v[i]);
		bit_io(1'b1);
		nak = r;
	endtask : put_byte
	// Register write: device address, pointer, data
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, d);
		start();
		put_byte({dev, 1'b0});
		put_byte(a);
		put_byte(d);
		stop();
	endtask : wr_reg
	// Register read: pointer, repeated start, one byte ended by no acknowledge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		start();
		put_byte({DEV_ADDR_DEF, 1'b0});
		put_byte(a);
		start();
		put_byte({DEV_ADDR_DEF, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1);
			d[i] = r;
		end
		bit_io(1'b1);
		stop();
	endtask : rd_reg
endmodule : ptpr_host_model

// *** verif/tb_top.sv ***
// Testbench: link traffic and port stimulus for the register slice
`timescale 1ns/100ps
module tb_top;
	import ptpr_pkg::*;
	localparam int TK = 10;
	logic clk = 1'b0, arst_n = 1'b0, block_power_on_class_fault = 1'b0;
	logic global_high_power_enable = 1'b0, event_pending = 1'b0;
	logic [7:0] port_mode = 8'h55, v = 8'h00, misc_def;
	logic [11:0] port_class = 12'h000;
	logic [3:0] discovery_busy = 4'h0, in_current_limit = 4'h0, power_good = 4'h0;
	logic [3:0] class_start = 4'h0, two_event_class_enable = 4'h4;
	logic [3:0] class_fault = 4'h0, auto_power_req = 4'h0, mps_absent = 4'h0;
	logic clr_marks = 1'b0;
	logic [2:0] per_class_high_power_enable = 3'h0;
	logic [9:0] seen = 10'h000;
	logic scl, sda_pull, sda_out, sda_oe, int_oe, clear_events, chip_soft_reset;
	logic [3:0] port_power_en, discovery_abort, port_soft_reset, class_trigger;
	logic [3:0] hold_mark_voltage, high_current_en, class_limit_en, discovery_sense_pin_hiz;
	int miscompares = 0, num_checks = 0, seed = 59592, ntrig = 0, t_last = 0, t_prev = 0;
	int cyc = 0;
	wire sda_line = !((sda_oe && !sda_out) || sda_pull);
	////////////////////////////////
	// Block under test and the host on its link pins
	ptpr_regs #(.TICK_CYC(TK)) i_ptpr_regs (.clk(clk), .arst_n(arst_n), .scl(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .int_oe(int_oe),
		.port_mode(port_mode), .port_class(port_class), .class_fault(class_fault),
		.block_power_on_class_fault(block_power_on_class_fault),
		.discovery_busy(discovery_busy), .auto_power_req(auto_power_req),
		.in_current_limit(in_current_limit), .power_good(power_good),
		.mps_absent(mps_absent), .class_start(class_start),
		.two_event_class_enable(two_event_class_enable),
		.global_high_power_enable(global_high_power_enable),
		.per_class_high_power_enable(per_class_high_power_enable),
		.event_pending(event_pending), .port_power_en(port_power_en),
		.discovery_abort(discovery_abort), .port_soft_reset(port_soft_reset),
		.clear_events(clear_events), .chip_soft_reset(chip_soft_reset),
		.class_trigger(class_trigger), .hold_mark_voltage(hold_mark_voltage),
		.high_current_en(high_current_en), .class_limit_en(class_limit_en),
		.discovery_sense_pin_hiz(discovery_sense_pin_hiz));
	ptpr_host_model i_ptpr_host_model (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
	// Clock
	always #5 clk = ~clk;
	// Latch pulse outputs, time the classification triggers of port 2
	always @(posedge clk) begin
		cyc <= cyc + 1;
		seen <= clr_marks ? 10'h000 :
			seen | {chip_soft_reset, clear_events, port_soft_reset, discovery_abort};
		if (clr_marks) ntrig <= 0;
		else if (class_trigger[2] === 1'b1) begin
			ntrig <= ntrig + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
	end
	////////////////////////////////
	// Compare and count
	task automatic chk(input string n, input logic [15:0] e, s);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Clear pulse marks and trigger count through the clocked process
	task automatic clear_marks();
		clr_marks = 1'b1;
		@(negedge clk);
		clr_marks = 1'b0;
	endtask : clear_marks
	// Register write, then let the pulses land
	task automatic wr(input logic [7:0] a, d);
		i_ptpr_host_model.wr_reg(DEV_ADDR_DEF, a, d);
		repeat (4) @(negedge clk);
	endtask : wr
	// Register read and compare
	task automatic rdchk(input string n, input logic [7:0] a, e);
		logic [7:0] d;
		i_ptpr_host_model.rd_reg(a, d);
		chk(n, e, d);
		@(negedge clk);
	endtask : rdchk
	// High current: enabled class and global, then startup or early timing
	function automatic logic exp_hc(logic [2:0] c, logic g, logic [2:0] e, logic x, logic s);
		return c >= CLASS_HP_MIN && c <= CLASS_HP_MAX && g && e[c[1:0]] && (s || (x && g));
	endfunction : exp_hc
	// Overload or unload a port, count cycles until it drops, two ticks of slack
	task automatic off_time(input string n, input int p, e, input bit d);
		int c = 0;
		if (d) mps_absent[p] = 1'b1;
		else in_current_limit[p] = 1'b1;
		while (port_power_en[p] === 1'b1 && c < 9000) begin
			@(negedge clk);
			c++;
		end
		mps_absent[p] = 1'b0;
		in_current_limit[p] = 1'b0;
		chk(n, e, (c > e + 2 * TK || c < e - 2 * TK) ? c : e);
	endtask : off_time
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	////////////////////////////////
	// Main sequence of tests
	initial begin
		block_power_on_class_fault = $random(seed);
		misc_def = MISC_RESET | {4'h0, block_power_on_class_fault, 3'h0};
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		repeat (6) @(negedge clk);
		rdchk("timer", REG_TIMER, TIMER_RESET);
		rdchk("misc", REG_MISC, misc_def);
		rdchk("button", REG_BUTTON, 8'h00);
		rdchk("global", REG_GLOBAL, 8'h00);
		wr(REG_IDENT, 8'hff);
		rdchk("ident", REG_IDENT, {IDENT_CODE_DEF, SILICON_VER_DEF});
		chk("sda_out", 1'b0, sda_out);
		rdchk("unmapped", 8'h30, 8'h00);
		i_ptpr_host_model.wr_reg(DEV_ADDR_DEF ^ 7'h01, REG_TIMER, 8'h5a);
		chk("nak", 1'b1, i_ptpr_host_model.nak);
		rdchk("nak_wr", REG_TIMER, 8'h00);
		v = $random(seed);
		wr(REG_TIMER, v);
		rdchk("timer_rw", REG_TIMER, v);
		$display("test registers done");
		wr(REG_BUTTON, 8'h01);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			{global_high_power_enable, per_class_high_power_enable} = $random(seed);
			{event_pending, port_class[2:0]} = $random(seed);
			global_high_power_enable = global_high_power_enable | i[0];
			power_good[0] = i > 3;
			wr(REG_MISC, v);
			rdchk("misc_rw", REG_MISC, {v[7:6], 2'h0, block_power_on_class_fault, v[2:0]});
			chk("cap", {4{v[MISC_CAP]}}, class_limit_en);
			chk("iso", {4{v[MISC_ISO]}}, discovery_sense_pin_hiz);
			chk("int", v[MISC_INT_EN] & event_pending, int_oe);
			chk("hp", exp_hc(port_class[2:0], global_high_power_enable,
				per_class_high_power_enable, v[0], power_good[0]), high_current_en[0]);
		end
		$display("test misc done");
		for (int m = 0; m < 4; m++) begin
			port_mode = {4{m[1:0]}};
			wr(REG_BUTTON, 8'h0f);
			chk("pwr_up", {4{m == 1 || m == 2}}, port_power_en);
			rdchk("self_clr", REG_BUTTON, 8'h00);
			wr(REG_BUTTON, 8'hf0);
			chk("pwr_dn", 4'h0, port_power_en);
		end
		port_mode = 8'h55;
		discovery_busy = 4'h2;
		clear_marks();
		wr(REG_BUTTON, 8'h02);
		chk("abort", 5'h12, {port_power_en[1], seen[3:0]});
		discovery_busy = 4'h0;
		wr(REG_BUTTON, 8'h01);
		clear_marks();
		wr(REG_GLOBAL, 8'h80);
		wr(REG_GLOBAL, 8'h01);
		chk("glb_pulse", 10'h110, seen);
		chk("port_rst", 4'h2, port_power_en);
		$display("test buttons done");
		power_good = 4'h0;
		wr(REG_MISC, MISC_RESET);
		wr(REG_TIMER, 8'hd5);
		wr(REG_BUTTON, 8'h04);
		off_time("start", 2, START_TK / 2 * TK, 1'b0);
		power_good = 4'h4;
		wr(REG_BUTTON, 8'h04);
		chk("restart_time_sel_zero", 1'b1, port_power_en[2]);
		wr(REG_TIMER, 8'h15);
		off_time("fault", 2, FAULT_TK / 2 * TK, 1'b0);
		wr(REG_BUTTON, 8'h04);
		chk("restart_time_sel_hold", 1'b0, port_power_en[2]);
		clear_marks();
		wr(REG_GLOBAL, 8'h10);
		chk("chip", 1'b1, seen[9]);
		rdchk("timer_def", REG_TIMER, TIMER_RESET);
		rdchk("misc_def", REG_MISC, misc_def);
		wr(REG_BUTTON, 8'h04);
		chk("restart_time_sel_clr", 1'b1, port_power_en[2]);
		wr(REG_TIMER, 8'h01);
		off_time("disc", 2, DISC_TK / 4 * TK, 1'b1);
		port_mode = 8'hff;
		auto_power_req = 4'h8;
		class_fault = 4'h8;
		repeat (3) @(negedge clk);
		chk("cls_blk", !block_power_on_class_fault, port_power_en[3]);
		class_fault = 4'h0;
		repeat (3) @(negedge clk);
		chk("auto_on", 1'b1, port_power_en[3]);
		auto_power_req = 4'h0;
		$display("test timers done");
		for (int m = 0; m < 4; m++) begin
			port_mode = {4{m[1:0]}};
			clear_marks();
			class_start = 4'h4;
			@(negedge clk);
			class_start = 4'h0;
			repeat (CGAP_TK * TK / 2) @(negedge clk);
			chk("hold", m > 1, hold_mark_voltage[2]);
			repeat (CGAP_TK * TK * 2) @(negedge clk);
			chk("trig", (m > 1) ? 3 : 1, ntrig);
			if (m > 1) chk("gap", CGAP_TK, (t_last - t_prev + TK / 2) / TK);
		end
		$display("test classification done");
		test_done();
	end
	// Watchdog, well past the expected run of some 0.6 ms
	initial begin
		#900000;
		miscompares++;
		test_done();
	end
endmodule : tb_top
